// ---- bench/timebase_unit_tb.sv ----
/*
 * Self-checking testbench for the timebase unit: APB register tests, prescaler,
 * overflow interrupt, halt and cascade counting.
 * Assumes the design answers each APB access in one cycle and runs on a 40 MHz pclk.
 */
module timebase_unit_tb
    import timebase_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [ADDR_W-1:0] A_COUNT = {2'h0, IDX_COUNT, 2'h0};
    localparam logic [ADDR_W-1:0] A_CTRL  = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] A_CASC  = {2'h0, IDX_CASC, 2'h0};
    localparam logic [ADDR_W-1:0] A_STAT  = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] A_CLR   = {2'h0, IDX_IRQ_CLEAR, 2'h0};
    localparam logic [ADDR_W-1:0] A_ENA   = {2'h0, IDX_IRQ_ENABLE, 2'h0};

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0]        pstrb = 4'h0;
    logic [3:0]        wstrb = 4'hf;
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
    logic              halt_mode = 1'b0;
    logic              global_irq_mask = 1'b0;
    logic              art_input_tick = 1'b0;
    logic              art_carry = 1'b0;
    logic              irq;
    int                miscompares = 0;
    int                n_compared = 0;

    timebase_unit i_timebase_unit (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .pstrb           (pstrb),
        .pready          (pready),
        .prdata          (prdata),
        .pslverr         (pslverr),
        .halt_mode       (halt_mode),
        .global_irq_mask (global_irq_mask),
        .art_input_tick  (art_input_tick),
        .art_carry       (art_carry),
        .irq             (irq)
    );

    // Free-running 40 MHz clock.
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    // Compares a seen value with the expected one and counts the result.
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an idle edge first keeps back-to-back calls from colliding.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                        output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= wstrb;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
            check(32'h0, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write that ignores the answer.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] rd;
        logic              e;
        xfer(1'b1, a, d, rd, e);
    endtask

    // Register read compared against an expected word.
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] rd;
        logic              e;
        xfer(1'b0, a, '0, rd, e);
        check(rd, exp);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Cuts a hung run short; the tests need well under 10000 cycles.
    initial
    begin
        #500000;
        miscompares++;
        wrap_up();
    end

    // Main test sequence.
    initial
    begin
        logic [DATA_W-1:0] rd;
        logic              e;
        int                div;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register.
        rd_chk(A_COUNT, 32'h00);
        rd_chk(A_CTRL, 32'h00);
        rd_chk(A_CASC, 32'h00);
        rd_chk(A_STAT, 32'h00);
        rd_chk(A_ENA, 32'h01);
        rd_chk(A_CLR, 32'h00);
        $display("test reset_values done");
        // Reserved and read-only bits, unmapped and unaligned addresses.
        wr(A_CTRL, 32'he7);
        rd_chk(A_CTRL, 32'h47);
        wr(A_CTRL, 32'h00);
        xfer(1'b0, 12'h100, '0, rd, e);
        check({31'h0, e}, 32'h1);
        check(rd, 32'h0);
        xfer(1'b1, 12'h0d9, 32'hff, rd, e);
        check({31'h0, e}, 32'h1);
        // A write without its low byte strobe stores nothing.
        wstrb = 4'he;
        wr(A_COUNT, 32'h5a);
        wstrb = 4'hf;
        rd_chk(A_COUNT, 32'h00);
        $display("test access_kinds done");
        // Every prescaler setting: four steps, then frozen while stopped.
        for (int s = 0; s < 8; s++)
        begin
            div = 2 << s;
            wr(A_COUNT, 32'h20 + s);
            wr(A_CTRL, 32'h08 | s);
            repeat (4 * div + div / 2 - 3) @(posedge pclk);
            wr(A_CTRL, s);
            rd_chk(A_COUNT, 32'h24 + s);
            repeat (2 * div) @(posedge pclk);
            rd_chk(A_COUNT, 32'h24 + s);
        end
        $display("test prescaler done");
        // Overflow with interrupt enabled, core mask, read clear and status clear.
        wr(A_COUNT, 32'hfe);
        wr(A_CTRL, 32'h18);
        repeat (10) @(posedge pclk);
        wr(A_CTRL, 32'h10);
        check({31'h0, irq}, 32'h1);
        global_irq_mask <= 1'b1;
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        global_irq_mask <= 1'b0;
        rd_chk(A_CTRL, 32'h30);
        rd_chk(A_CTRL, 32'h10);
        check({31'h0, irq}, 32'h1);
        wr(A_CLR, 32'h01);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(A_STAT, 32'h00);
        // Overflow with interrupt disabled, then enable paths.
        wr(A_COUNT, 32'hff);
        wr(A_CTRL, 32'h08);
        repeat (6) @(posedge pclk);
        wr(A_CTRL, 32'h00);
        check({31'h0, irq}, 32'h0);
        rd_chk(A_STAT, 32'h01);
        wr(A_CTRL, 32'h10);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(A_ENA, 32'h00);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        wr(A_CLR, 32'h01);
        wr(A_ENA, 32'h01);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(A_CTRL, 32'h30);
        $display("test overflow_irq done");
        // Halt freezes a running counter.
        halt_mode <= 1'b1;
        wr(A_COUNT, 32'h40);
        wr(A_CTRL, 32'h08);
        repeat (20) @(posedge pclk);
        rd_chk(A_COUNT, 32'h40);
        wr(A_CTRL, 32'h00);
        halt_mode <= 1'b0;
        $display("test halt done");
        // Cascade: steps only on counter clock ticks with the lower byte at its top.
        wr(A_CASC, 32'h00);
        wr(A_COUNT, 32'h05);
        art_input_tick <= 1'b1;
        wr(A_CTRL, 32'h48);
        repeat (10) @(posedge pclk);
        rd_chk(A_COUNT, 32'h05);
        art_carry <= 1'b1;
        repeat (3) @(posedge pclk);
        art_carry <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_chk(A_COUNT, 32'h08);
        wr(A_CASC, 32'h02);
        art_carry <= 1'b1;
        repeat (16) @(posedge pclk);
        art_carry <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_chk(A_COUNT, 32'h0c);
        rd_chk(A_CTRL, 32'h48);
        wr(A_CTRL, 32'h00);
        art_input_tick <= 1'b0;
        $display("test cascade done");
        wrap_up();
    end
endmodule

// ---- hw/tick_divider.sv ----
/*
 * Power-of-two tick divider: emits one tick every 2**min(shift, 8) step pulses.
 * Assumes step and run come from logic on the same clock.
 */
module tick_divider
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       step,
    input  wire logic [3:0] shift,
    output logic            tick
);

    import timebase_pkg::*;

    logic [7:0] phase;
    logic [8:0] wide_mask;
    logic [7:0] mask;

    // Low shift bits all set marks the last step of a period.
    assign wide_mask = (9'h001 << shift) - 9'h001;
    assign mask      = wide_mask[7:0];
    assign tick      = run & step & ((phase & mask) == mask);

    // Phase clears while stopped and holds while step is low.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase <= COUNT_RESET;
        else if (!run)
            phase <= COUNT_RESET;
        else if (step)
            phase <= phase + COUNT_ONE;
    end

endmodule

// ---- hw/timebase_pkg.sv ----
/*
 * Constants, register map and address decode for the periodic timebase counter.
 * Assumes a 32-bit APB master and one clock, pclk, at 40 MHz.
 */
package timebase_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_COUNT      = 8'h36;
    localparam logic [7:0] IDX_CTRL       = 8'h37;
    localparam logic [7:0] IDX_CASC       = 8'h38;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h39;
    localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h3a;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h3b;

    // Control/status field positions.
    localparam int unsigned BIT_RESERVED     = 7;
    localparam int unsigned BIT_CASCADE      = 6;
    localparam int unsigned BIT_OVERFLOW     = 5;
    localparam int unsigned BIT_IRQ_EN       = 4;
    localparam int unsigned BIT_RUN          = 3;
    localparam int unsigned SCALE_MSB        = 2;
    localparam int unsigned SCALE_LSB        = 0;
    localparam int unsigned CLKDIV_MSB       = 2;
    localparam int unsigned CLKDIV_LSB       = 0;
    localparam int unsigned BIT_STATUS_EVENT = 0;

    // Reset values and limits.
    localparam logic [7:0] COUNT_RESET        = 8'h00;
    localparam logic [7:0] COUNT_MAX          = 8'hff;
    localparam logic [7:0] COUNT_ONE          = 8'h01;
    localparam logic [2:0] FIELD3_RESET       = 3'h0;
    localparam logic       IRQ_ENABLE_RESET   = 1'b1;
    localparam logic [3:0] SCALE_SHIFT_OFFSET = 4'h1;

    // Register selected by an address.
    typedef enum {
        SEL_COUNT,
        SEL_CTRL,
        SEL_CASC,
        SEL_IRQ_STATUS,
        SEL_IRQ_CLEAR,
        SEL_IRQ_ENABLE,
        SEL_NONE
    } reg_sel_t;

    // Decodes a byte address into a register; unaligned or unknown gives none.
    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == 2'h0)
        begin
            unique case (addr[9:2])
                IDX_COUNT:      sel = SEL_COUNT;
                IDX_CTRL:       sel = SEL_CTRL;
                IDX_CASC:       sel = SEL_CASC;
                IDX_IRQ_STATUS: sel = SEL_IRQ_STATUS;
                IDX_IRQ_CLEAR:  sel = SEL_IRQ_CLEAR;
                IDX_IRQ_ENABLE: sel = SEL_IRQ_ENABLE;
                default:        sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

endpackage

// ---- hw/timebase_unit.sv ----
/*
 * Periodic timebase counter with prescaler, overflow flag, interrupt and
 * cascading with the auto-reload timer, reached as an APB slave.
 * Assumes halt_mode, global_irq_mask, art_input_tick and art_carry come from
 * logic on pclk; art_carry is high while the lower byte is at its maximum.
 */
// The APB interface to the registers was chosen for this implementation.
module timebase_unit
(
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [timebase_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [timebase_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic                                  pready,
    output logic [timebase_pkg::DATA_W-1:0]       prdata,
    output logic                                  pslverr,
    input  wire logic                             halt_mode,
    input  wire logic                             global_irq_mask,
    input  wire logic                             art_input_tick,
    input  wire logic                             art_carry,
    output logic                                  irq
);

    import timebase_pkg::*;

    logic [7:0] count_value_field;
    logic       cascade;
    logic       overflow_flag;
    logic       overflow_irq_enable;
    logic       counter_run_enable;
    logic [2:0] prescaler_select;
    logic [2:0] reload_timer_clock_divide;
    logic       irq_status;
    logic       irq_enable;
    logic       flag_seen;
    logic [7:0] read_byte;
    logic       setup;
    logic       access_done;
    logic       wr;
    logic       rd;
    logic       wr_count;
    logic       prescale_tick;
    logic       art_tick;
    logic       count_step;
    logic       wrap;
    logic       fast_div;
    reg_sel_t   setup_sel;
    reg_sel_t   access_sel;

    // Bus phase decode; address stays stable through the access phase.
    assign setup       = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign setup_sel   = decode_addr(paddr);
    assign access_sel  = decode_addr(paddr);
    assign wr          = access_done & pwrite & pstrb[0];
    assign rd          = access_done & ~pwrite;
    assign wr_count    = wr & (access_sel == SEL_COUNT);

    // Own prescaler; frozen in HALT, cleared while stopped.
    tick_divider u_prescale_div (
        .clk   (pclk),
        .rst_n (presetn),
        .run   (counter_run_enable),
        .step  (~halt_mode),
        .shift ({1'b0, prescaler_select} + SCALE_SHIFT_OFFSET),
        .tick  (prescale_tick)
    );

    // Auto-reload counter clock, dividing its input clock by 1 to 128.
    tick_divider u_art_div (
        .clk   (pclk),
        .rst_n (presetn),
        .run   (cascade),
        .step  (art_input_tick & ~halt_mode),
        .shift ({1'b0, reload_timer_clock_divide}),
        .tick  (art_tick)
    );

    // Step source: own prescaler, or the lower byte wrapping on its counter clock.
    assign count_step = counter_run_enable & ~halt_mode
                        & (cascade ? (art_tick & art_carry) : prescale_tick);
    assign wrap       = count_step & (count_value_field == COUNT_MAX) & ~wr_count;
    assign fast_div   = counter_run_enable & ~halt_mode & (prescaler_select == FIELD3_RESET);

    // Count register: software write replaces the count, else it advances.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value_field <= COUNT_RESET;
        else if (wr_count)
            count_value_field <= 8'(pwdata);
        else if (count_step)
            count_value_field <= count_value_field + COUNT_ONE;
    end

    // Software-written control bits; reserved bit and flag are not stored.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cascade             <= 1'b0;
            overflow_irq_enable <= 1'b0;
            counter_run_enable  <= 1'b0;
            prescaler_select    <= FIELD3_RESET;
        end
        else if (wr && access_sel == SEL_CTRL)
        begin
            cascade             <= pwdata[BIT_CASCADE];
            overflow_irq_enable <= pwdata[BIT_IRQ_EN];
            counter_run_enable  <= pwdata[BIT_RUN];
            prescaler_select    <= pwdata[SCALE_MSB:SCALE_LSB];
        end
    end

    // Counter clock divide for cascaded operation.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reload_timer_clock_divide <= FIELD3_RESET;
        else if (wr && access_sel == SEL_CASC)
            reload_timer_clock_divide <= pwdata[CLKDIV_MSB:CLKDIV_LSB];
    end

    // Overflow flag: set wins over a read clear; only a seen flag is cleared.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overflow_flag <= 1'b0;
        else if (wrap)
            overflow_flag <= 1'b1;
        else if (rd && access_sel == SEL_CTRL && flag_seen)
            overflow_flag <= 1'b0;
    end

    // Sticky event status, cleared by a one written to the clear register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= 1'b0;
        else if (wrap)
            irq_status <= 1'b1;
        else if (wr && access_sel == SEL_IRQ_CLEAR && pwdata[BIT_STATUS_EVENT])
            irq_status <= 1'b0;
    end

    // Event enable register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_enable <= IRQ_ENABLE_RESET;
        else if (wr && access_sel == SEL_IRQ_ENABLE)
            irq_enable <= pwdata[BIT_STATUS_EVENT];
    end

    // Interrupt level, gated by overflow_irq_enable, the event enable bit and the core's mask.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= irq_status & irq_enable & overflow_irq_enable & ~global_irq_mask;
    end

    // Read multiplexer; the clear register reads as zero.
    always_comb
    begin
        read_byte = COUNT_RESET;
        unique case (setup_sel)
            SEL_COUNT:      read_byte = count_value_field;
            SEL_CTRL:
            begin
                read_byte                 = 8'(prescaler_select);
                read_byte[BIT_RESERVED]   = 1'b0;
                read_byte[BIT_CASCADE]    = cascade;
                read_byte[BIT_OVERFLOW]   = overflow_flag;
                read_byte[BIT_IRQ_EN]     = overflow_irq_enable;
                read_byte[BIT_RUN]        = counter_run_enable;
            end
            SEL_CASC:       read_byte = 8'(reload_timer_clock_divide);
            SEL_IRQ_STATUS: read_byte[BIT_STATUS_EVENT] = irq_status;
            SEL_IRQ_ENABLE: read_byte[BIT_STATUS_EVENT] = irq_enable;
            SEL_IRQ_CLEAR:  read_byte = COUNT_RESET;
            SEL_NONE:       read_byte = COUNT_RESET;
        endcase
    end

    // Bus answer: data, ready and error captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready    <= 1'b0;
            prdata    <= '0;
            pslverr   <= 1'b0;
            flag_seen <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & (setup_sel == SEL_NONE);
            if (setup)
            begin
                prdata    <= DATA_W'(read_byte);
                flag_seen <= (setup_sel == SEL_CTRL) & overflow_flag;
            end
        end
    end

    // Checks on counting, the flag, the interrupt and the bus answer.
    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        !counter_run_enable && !wr_count |=> $stable(count_value_field);
    endproperty
    a_frozen: assert property (p_frozen) else $error("count moved while stopped");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        count_step && !wr_count |=> count_value_field == $past(count_value_field) + COUNT_ONE;
    endproperty
    a_advance: assert property (p_advance) else $error("count did not advance");

    property p_wrap_flag;
        @(posedge pclk) disable iff (!presetn)
        wrap |=> overflow_flag && irq_status && count_value_field == COUNT_RESET;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        irq |-> $past(overflow_irq_enable) && !$past(global_irq_mask) && $past(irq_status);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without cause");

    property p_write_count;
        @(posedge pclk) disable iff (!presetn)
        wr_count |=> count_value_field == 8'($past(pwdata));
    endproperty
    a_write_count: assert property (p_write_count) else $error("count write lost");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        setup && setup_sel == SEL_CTRL |=> pready && !prdata[BIT_RESERVED];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read one");

    property p_flag_write;
        @(posedge pclk) disable iff (!presetn)
        wr && access_sel == SEL_CTRL && !wrap |=> overflow_flag == $past(overflow_flag);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("write changed flag");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        halt_mode && !wr_count |=> $stable(count_value_field);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved in halt");

    property p_cascade;
        @(posedge pclk) disable iff (!presetn)
        cascade && !wr_count && counter_run_enable && !halt_mode && art_tick && art_carry
        |=> count_value_field == $past(count_value_field) + COUNT_ONE;
    endproperty
    a_cascade: assert property (p_cascade) else $error("upper byte missed carry");

    property p_div_two;
        @(posedge pclk) disable iff (!presetn)
        fast_div ##1 fast_div |-> prescale_tick != $past(prescale_tick);
    endproperty
    a_div_two: assert property (p_div_two) else $error("prescaler not dividing by two");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        wr && access_sel == SEL_CTRL
        |=> cascade == $past(pwdata[BIT_CASCADE])
            && overflow_irq_enable == $past(pwdata[BIT_IRQ_EN]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_reset_val;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> count_value_field == COUNT_RESET && !counter_run_enable && !cascade;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset state");

    c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap);
    c_cascade: cover property (@(posedge pclk) disable iff (!presetn) cascade && count_step);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
        overflow_flag ##1 !overflow_flag);
    c_halt: cover property (@(posedge pclk) disable iff (!presetn) halt_mode && counter_run_enable);

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
        rd && access_sel == SEL_CTRL && flag_seen && !wrap |=> !overflow_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

    property p_mask;
        @(posedge pclk) disable iff (!presetn)
        global_irq_mask |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt reached core");

endmodule
